// [rtl/udtb_regs.vh]
// constants for the descriptor table base register bank
// assumes inclusion by the bank's design and verification files
`ifndef UDTB_REGS_VH
`define UDTB_REGS_VH

// register byte offsets on the bus
`define UDTB_ADDR_W        12
`define UDTB_PAGE1_OFF     12'h000
`define UDTB_PAGE2_OFF     12'h004
`define UDTB_PAGE3_OFF     12'h008

// register select codes, zero means unmapped
`define UDTB_SEL_NONE      2'h0
`define UDTB_SEL_PAGE1     2'h1
`define UDTB_SEL_PAGE2     2'h2
`define UDTB_SEL_PAGE3     2'h3

// implemented-bit masks and reset values of the byte fields
`define UDTB_PAGE1_MASK    8'hFE
`define UDTB_PAGE2_MASK    8'hFF
`define UDTB_PAGE3_MASK    8'hFF
`define UDTB_PAGE_RESET    8'h00

// field positions inside the assembled base address
`define UDTB_LOW_LSB       9
`define UDTB_MID_LSB       16
`define UDTB_TOP_LSB       24
`define UDTB_ALIGN_BITS    9
`define UDTB_ALIGN_ZERO    9'h000

// descriptor entry layout inside the table
`define UDTB_ENTRY_IDX_W   6
`define UDTB_ENTRY_SHIFT   3
`define UDTB_ENTRY_PAD     3'h0

// bus encodings
`define UDTB_HTRANS_NONSEQ 2'h2
`define UDTB_HSIZE_BYTE    3'h0
`define UDTB_HSIZE_HALF    3'h1
`define UDTB_HRESP_OKAY    1'h0

`endif

// [rtl/udtb_page_reg.v]
// one byte-wide page register of the table base bank
// assumes a write strobe already qualified by address and byte lane
`timescale 1ns/1ns
`include "udtb_regs.vh"

module udtb_page_reg #(
    parameter [7:0] MASK      = 8'hFF,
    parameter [7:0] RESET_VAL = 8'h00
) (
    input  wire       hclk,
    input  wire       hresetn,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    output wire [7:0] q
);

    reg  [7:0] field_r;
    wire [7:0] field_nxt;

    // unimplemented bits never load, so they read zero forever
    assign field_nxt = (field_r & ~MASK) | (wr_data & MASK);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            field_r <= RESET_VAL & MASK;
        end else if (wr_en) begin
            field_r <= field_nxt;
        end
    end

    assign q = field_r;

endmodule

// [rtl/udtb_ahb_slave.v]
// address and data phase tracking for the bank's AHB-Lite slave port
// assumes one master, hready fed back from the bank's own hreadyout
`timescale 1ns/1ns
`include "udtb_regs.vh"

module udtb_ahb_slave #(
    parameter ADDR_W = `UDTB_ADDR_W
) (
    input  wire              hclk,
    input  wire              hresetn,
    input  wire              hsel,
    input  wire [ADDR_W-1:0] haddr,
    input  wire [1:0]        htrans,
    input  wire              hwrite,
    input  wire [2:0]        hsize,
    input  wire              hready,
    output wire              rd_take,
    output wire [ADDR_W-1:0] rd_addr,
    output wire              wr_en,
    output wire [ADDR_W-1:0] wr_addr
);

    reg              wr_pend_r;
    reg              wr_lane0_r;
    reg [ADDR_W-1:0] wr_addr_r;
    wire             take;

    // only byte lane 0 carries implemented bits
    function lane0_hit;
        input [2:0] size;
        input [1:0] lo;
        begin
            if (size == `UDTB_HSIZE_BYTE)
                lane0_hit = (lo == 2'h0);
            else if (size == `UDTB_HSIZE_HALF)
                lane0_hit = ~lo[1];
            else
                lane0_hit = 1'b1;
        end
    endfunction

    // htrans[1] covers NONSEQ and SEQ alike
    assign take    = hsel & hready & htrans[1];
    assign rd_take = take & ~hwrite;
    assign rd_addr = haddr;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r  <= 1'b0;
            wr_lane0_r <= 1'b0;
            wr_addr_r  <= {ADDR_W{1'b0}};
        end else begin
            wr_pend_r <= take & hwrite;
            if (take & hwrite) begin
                wr_lane0_r <= lane0_hit(hsize, haddr[1:0]);
                wr_addr_r  <= haddr;
            end
        end
    end

    // write lands at the end of the data phase, when hwdata is valid
    assign wr_en   = wr_pend_r & wr_lane0_r;
    assign wr_addr = wr_addr_r;

endmodule

// [rtl/udtb_top.v]
// descriptor table base register bank with AHB-Lite register access
// assumes hclk is the peripheral bus clock, hresetn the power-on reset,
// and that the usb engine shares hclk
`timescale 1ns/1ns
`include "udtb_regs.vh"

module udtb_top #(
    parameter ADDR_W = `UDTB_ADDR_W
) (
    input  wire                         hclk,
    input  wire                         hresetn,
    input  wire                         hsel,
    input  wire [ADDR_W-1:0]            haddr,
    input  wire [1:0]                   htrans,
    input  wire                         hwrite,
    input  wire [2:0]                   hsize,
    input  wire [31:0]                  hwdata,
    input  wire                         hready,
    output wire [31:0]                  hrdata,
    output wire                         hreadyout,
    output wire                         hresp,
    input  wire                         entry_req,
    input  wire [`UDTB_ENTRY_IDX_W-1:0] entry_idx,
    output wire [31:0]                  table_base_addr,
    output wire                         table_base_upd,
    output wire [31:0]                  entry_addr,
    output wire                         entry_ack
);

    wire              rd_take;
    wire [ADDR_W-1:0] rd_addr;
    wire              wr_en;
    wire [ADDR_W-1:0] wr_addr;
    wire [1:0]        wr_sel;
    wire [1:0]        rd_sel;
    wire [7:0]        page1_q;
    wire [7:0]        page2_q;
    wire [7:0]        page3_q;
    wire [7:0]        page1_fwd;
    wire [7:0]        page2_fwd;
    wire [7:0]        page3_fwd;
    wire              wr_page1;
    wire              wr_page2;
    wire              wr_page3;
    wire [31:0]       base_nxt;

    reg  [31:0]       hrdata_r;
    reg  [31:0]       hrdata_nxt;
    reg               hreadyout_r;
    reg  [31:0]       base_r;
    reg               base_upd_r;
    reg  [31:0]       entry_addr_r;
    reg               entry_ack_r;

    // address to page select; anything else is unmapped
    function [1:0] page_sel;
        input [ADDR_W-1:0] addr;
        begin
            case (addr)
                `UDTB_PAGE1_OFF: page_sel = `UDTB_SEL_PAGE1;
                `UDTB_PAGE2_OFF: page_sel = `UDTB_SEL_PAGE2;
                `UDTB_PAGE3_OFF: page_sel = `UDTB_SEL_PAGE3;
                default:         page_sel = `UDTB_SEL_NONE;
            endcase
        end
    endfunction

    // three page fields into one aligned table base
    function [31:0] assemble_base;
        input [7:0] p1;
        input [7:0] p2;
        input [7:0] p3;
        begin
            assemble_base = {p3,
                             p2,
                             p1[7:1],
                             `UDTB_ALIGN_ZERO};
        end
    endfunction

    udtb_ahb_slave #(
        .ADDR_W (ADDR_W)
    ) u_slave (
        .hclk    (hclk),
        .hresetn (hresetn),
        .hsel    (hsel),
        .haddr   (haddr),
        .htrans  (htrans),
        .hwrite  (hwrite),
        .hsize   (hsize),
        .hready  (hready),
        .rd_take (rd_take),
        .rd_addr (rd_addr),
        .wr_en   (wr_en),
        .wr_addr (wr_addr)
    );

    assign wr_sel   = page_sel(wr_addr);
    assign rd_sel   = page_sel(rd_addr);
    assign wr_page1 = wr_en & (wr_sel == `UDTB_SEL_PAGE1);
    assign wr_page2 = wr_en & (wr_sel == `UDTB_SEL_PAGE2);
    assign wr_page3 = wr_en & (wr_sel == `UDTB_SEL_PAGE3);

    // upper data lanes never reach the fields
    udtb_page_reg #(
        .MASK      (`UDTB_PAGE1_MASK),
        .RESET_VAL (`UDTB_PAGE_RESET)
    ) u_page1 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_page1),
        .wr_data (hwdata[7:0]),
        .q       (page1_q)
    );

    udtb_page_reg #(
        .MASK      (`UDTB_PAGE2_MASK),
        .RESET_VAL (`UDTB_PAGE_RESET)
    ) u_page2 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_page2),
        .wr_data (hwdata[7:0]),
        .q       (page2_q)
    );

    udtb_page_reg #(
        .MASK      (`UDTB_PAGE3_MASK),
        .RESET_VAL (`UDTB_PAGE_RESET)
    ) u_page3 (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_page3),
        .wr_data (hwdata[7:0]),
        .q       (page3_q)
    );

    // a read right behind a write to the same page sees the new value,
    // since the read data is latched in the same edge the write lands
    assign page1_fwd = wr_page1 ? (hwdata[7:0] & `UDTB_PAGE1_MASK) : page1_q;
    assign page2_fwd = wr_page2 ? (hwdata[7:0] & `UDTB_PAGE2_MASK) : page2_q;
    assign page3_fwd = wr_page3 ? (hwdata[7:0] & `UDTB_PAGE3_MASK) : page3_q;

    always @* begin
        hrdata_nxt = 32'h00000000;
        case (rd_sel)
            `UDTB_SEL_PAGE1: hrdata_nxt = {24'h000000, page1_fwd};
            `UDTB_SEL_PAGE2: hrdata_nxt = {24'h000000, page2_fwd};
            `UDTB_SEL_PAGE3: hrdata_nxt = {24'h000000, page3_fwd};
            default:         hrdata_nxt = 32'h00000000;
        endcase
    end

    // read data is held through idle cycles until the next read
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r    <= 32'h00000000;
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            if (rd_take) begin
                hrdata_r <= hrdata_nxt;
            end
        end
    end

    // zero wait state, every transfer answers OKAY
    assign hrdata    = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp     = `UDTB_HRESP_OKAY;

    // forwarded fields keep the base change and its update pulse in one cycle
    assign base_nxt = assemble_base(page1_fwd, page2_fwd, page3_fwd);

    // base output loads on the same edge as the page field
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            base_r     <= 32'h00000000;
            base_upd_r <= 1'b0;
        end else begin
            base_r     <= base_nxt;
            base_upd_r <= wr_page1 | wr_page2 | wr_page3;
        end
    end

    assign table_base_addr = base_r;
    assign table_base_upd  = base_upd_r;

    // entry offset fits below the alignment, so an or equals an add
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_addr_r <= 32'h00000000;
            entry_ack_r  <= 1'b0;
        end else begin
            entry_ack_r <= entry_req;
            if (entry_req) begin
                entry_addr_r <= base_r | {23'h000000, entry_idx, `UDTB_ENTRY_PAD};
            end
        end
    end

    assign entry_addr = entry_addr_r;
    assign entry_ack  = entry_ack_r;

endmodule

// [verification/udtb_chk_sva.sv]
// assertions on the ports of the table base register bank
// assumes a single AHB-Lite master and hready tied to hreadyout
`timescale 1ns/1ns
`include "udtb_regs.vh"

module udtb_chk #(
    parameter ADDR_W = `UDTB_ADDR_W
) (
    input logic              hclk,
    input logic              hresetn,
    input logic              hsel,
    input logic [ADDR_W-1:0] haddr,
    input logic [1:0]        htrans,
    input logic              hwrite,
    input logic [2:0]        hsize,
    input logic [31:0]       hwdata,
    input logic              hready,
    input logic [31:0]       hrdata,
    input logic              hreadyout,
    input logic              hresp,
    input logic              entry_req,
    input logic [5:0]        entry_idx,
    input logic [31:0]       table_base_addr,
    input logic              table_base_upd,
    input logic [31:0]       entry_addr,
    input logic              entry_ack
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire tk = hsel && hready && htrans[1];
    wire wr = tk && hwrite && hsize == 3'h2;
    wire rd = tk && !hwrite;

    ready_after_reset_a: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus not ready after reset");
    base_aligned_a: assert property (table_base_addr[8:0] == 9'h000)
        else $error("base low bits not zero");
    base_change_upd_a: assert property ($changed(table_base_addr) |-> table_base_upd)
        else $error("base changed without update pulse");
    top_byte_write_a: assert property (wr && haddr == `UDTB_PAGE3_OFF |-> ##2
        table_base_addr[31:24] == $past(hwdata[7:0], 1)) else $error("top bits wrong");
    low_bits_write_a: assert property (wr && haddr == `UDTB_PAGE1_OFF |-> ##2
        table_base_addr[15:9] == $past(hwdata[7:1], 1)) else $error("low bits wrong");
    mid_write_upd_a: assert property (wr && haddr == `UDTB_PAGE2_OFF |-> ##2
        table_base_upd && table_base_addr[23:16] == $past(hwdata[7:0], 1))
        else $error("mid bits or update pulse wrong");
    entry_answer_a: assert property (entry_req |=> entry_ack && entry_addr ==
        ($past(table_base_addr) | {$past(entry_idx), 3'h0})) else $error("entry answer wrong");
    no_spurious_ack_a: assert property (!entry_req |=> !entry_ack)
        else $error("ack without request");
    upper_read_zero_a: assert property (rd |=> hrdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    page1_bit0_a: assert property (rd && haddr == `UDTB_PAGE1_OFF |=> !hrdata[0])
        else $error("page one bit 0 set");
endmodule

bind udtb_top udtb_chk #(.ADDR_W(ADDR_W)) u_chk (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hsel            (hsel),
    .haddr           (haddr),
    .htrans          (htrans),
    .hwrite          (hwrite),
    .hsize           (hsize),
    .hwdata          (hwdata),
    .hready          (hready),
    .hrdata          (hrdata),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .entry_req       (entry_req),
    .entry_idx       (entry_idx),
    .table_base_addr (table_base_addr),
    .table_base_upd  (table_base_upd),
    .entry_addr      (entry_addr),
    .entry_ack       (entry_ack)
);

// [verification/udtb_engine_model.sv]
// usb engine model asking for descriptor entry addresses
// assumes the bench counts seen and bad on each rising hclk
`timescale 1ns/1ns

module udtb_engine_model (
    input  logic        hclk,
    input  logic        hresetn,
    input  logic        en,
    input  logic [31:0] table_base_addr,
    input  logic [31:0] entry_addr,
    input  logic        entry_ack,
    output logic        entry_req,
    output logic [5:0]  entry_idx,
    output logic [31:0] exp,
    output logic        seen,
    output logic        bad
);
    logic [7:0] s_r;
    logic       pend_r;
    // random gaps give both prompt and slow request streams
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= 8'h4D;
            entry_req <= 1'b0;
            entry_idx <= 6'h00;
            pend_r <= 1'b0;
            exp <= 32'h00000000;
        end else begin
            s_r <= {s_r[6:0], s_r[7] ^ s_r[5] ^ s_r[4] ^ s_r[3]};
            entry_req <= en & s_r[0];
            entry_idx <= s_r[6:1];
            pend_r <= entry_req;
            exp <= table_base_addr | {entry_idx, 3'h0};
        end
    end
    assign seen = pend_r;
    assign bad = pend_r ? (entry_ack !== 1'b1 || entry_addr !== exp) : entry_ack !== 1'b0;
endmodule

// [verification/usb_descriptor_table_base_regs_test.sv]
// self-checking bench of the table base register bank
// assumes udtb_top with its checker bound and the engine model beside it
`timescale 1ns/1ns
`include "udtb_regs.vh"

module usb_descriptor_table_base_regs_test;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, en = 0;
    logic        hreadyout, hresp, table_base_upd, entry_ack, entry_req, seen, bad;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h00000000, hrdata, table_base_addr, entry_addr, exp, q, d;
    logic [31:0] st = 32'h0000004C;
    logic [5:0]  entry_idx;
    logic [7:0]  pg [3];
    int          err_count = 0, samples_checked = 0, k;

    always #20 hclk = ~hclk;
    udtb_top u_dut (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .hsel            (hsel),
        .haddr           (haddr),
        .htrans          (htrans),
        .hwrite          (hwrite),
        .hsize           (hsize),
        .hwdata          (hwdata),
        .hready          (hreadyout),
        .hrdata          (hrdata),
        .hreadyout       (hreadyout),
        .hresp           (hresp),
        .entry_req       (entry_req),
        .entry_idx       (entry_idx),
        .table_base_addr (table_base_addr),
        .table_base_upd  (table_base_upd),
        .entry_addr      (entry_addr),
        .entry_ack       (entry_ack)
    );
    udtb_engine_model u_eng (
        .hclk            (hclk),
        .hresetn         (hresetn),
        .en              (en),
        .table_base_addr (table_base_addr),
        .entry_addr      (entry_addr),
        .entry_ack       (entry_ack),
        .entry_req       (entry_req),
        .entry_idx       (entry_idx),
        .exp             (exp),
        .seen            (seen),
        .bad             (bad)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [31:0] expb();
        return {pg[2], pg[1], pg[0][7:1], 9'h000};
    endfunction

    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= `UDTB_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task conclude;
        $display("errors %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge hclk) begin
        if (hresetn && seen)
            chk("entry_addr", exp, entry_addr);
        if (hresetn)
            chk("entry_ack", {31'h0, seen}, {31'h0, entry_ack});
        if (hresetn)
            chk("engine verdict", 32'h00000000, {31'h0, bad});
    end

    initial begin
        repeat (5000) @(posedge hclk);
        err_count++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 12'(i * 4), 32'h00000000);
            chk("reset read", 32'h00000000, q);
        end
        en <= 1'b1;
        pg = '{default: 8'h00};
        // all-ones first hits every unimplemented bit
        for (int i = 0; i < 40; i++) begin
            st = xs(st);
            k = i < 3 ? i : st[15:0] % 3;
            d = i < 3 ? 32'hFFFFFFFF : st;
            bus(1'b1, 12'(k * 4), d);
            pg[k] = d[7:0] & (k == 0 ? `UDTB_PAGE1_MASK : 8'hFF);
            bus(1'b0, 12'(k * 4), 32'h00000000);
            chk("page read", {24'h000000, pg[k]}, q);
            chk("table base", expb(), table_base_addr);
        end
        bus(1'b1, 12'h00C, 32'hFFFFFFFF);
        bus(1'b0, 12'h00C, 32'h00000000);
        chk("unmapped read", 32'h00000000, q);
        chk("base after unmapped", expb(), table_base_addr);
        en <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("base after reset", 32'h00000000, table_base_addr);
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, 12'(i * 4), 32'h00000000);
            chk("page after reset", 32'h00000000, q);
        end
        conclude();
    end
endmodule
